//--- hw/gprod_regs.vh
/*
  Constants for the general register file and operand derivation block:
  addressing mode codes, fixed register numbers, reset values and field widths.
  Assumes it is included by its bare name from the design file.
*/
`ifndef GPROD_REGS_VH
`define GPROD_REGS_VH

// ==========================================================================
// Word and register file geometry
// ==========================================================================
`define GPROD_WORD_W 16
`define GPROD_NUM_REGS 16
`define GPROD_REG_IDX_W 4
`define GPROD_DISP_W 8
`define GPROD_EXP_W 8
`define GPROD_REG_RESET 16'h0000

// ==========================================================================
// Addressing mode codes on MODE_IN
// ==========================================================================
`define GPROD_MODE_REG_DIRECT 4'h0
`define GPROD_MODE_MEM_DIRECT 4'h1
`define GPROD_MODE_MEM_INDIRECT 4'h2
`define GPROD_MODE_IMMEDIATE_LONG 4'h3
`define GPROD_MODE_SHORT_POS 4'h4
`define GPROD_MODE_SHORT_NEG 4'h5
`define GPROD_MODE_COUNTER_REL 4'h6
`define GPROD_MODE_BASE 4'h7
`define GPROD_MODE_BASE_INDEXED 4'h8

// ==========================================================================
// Fixed register numbers
// ==========================================================================
`define GPROD_REG_NO_INDEX 4'h0
`define GPROD_REG_DOUBLE_BASE_FIRST 4'h0
`define GPROD_REG_SINGLE_BASE_FIRST 4'h2
`define GPROD_REG_BASE_FIRST 4'hc
`define GPROD_REG_STACK_PTR 4'hf

// ==========================================================================
// Short immediate and displacement expansion
// ==========================================================================
`define GPROD_SHORT_ONE 16'h0001
`define GPROD_SHORT_NEG_HIGH 12'hfff
`define GPROD_ZERO_HIGH_BYTE 8'h00
`define GPROD_ZERO_HIGH_NIBBLES 12'h000

`endif

//--- hw/gprod_top.v
/*
  General register file with second-operand and operand-address derivation.
  Assumes the decoder presents mode, fields, postword and instruction counter
  together with a one-cycle START_IN, and that the memory unit answers a
  pointer read with MEM_DATA_VALID_IN on the same or any later clock.
*/
`timescale 1ns/1ns
`include "gprod_regs.vh"

module gprod_top #(
  parameter WORD_W = `GPROD_WORD_W,
  parameter NUM_REGS = `GPROD_NUM_REGS
) (
  input wire CLK_SYS_IN,
  input wire RST_N_IN,
  input wire WR_EN_IN,
  input wire [3:0] WR_ADDR_IN,
  input wire [15:0] WR_DATA_IN,
  input wire PUSH_MULTIPLE_OP_IN,
  input wire POP_MULTIPLE_OP_IN,
  input wire [3:0] RD_A_ADDR_IN,
  input wire [3:0] RD_B_ADDR_IN,
  input wire START_IN,
  input wire [3:0] MODE_IN,
  input wire [3:0] REG_FIELD_IN,
  input wire [3:0] INDEX_FIELD_IN,
  input wire [1:0] BASE_SEL_IN,
  input wire [7:0] DISP_IN,
  input wire [3:0] SHORT_FIELD_IN,
  input wire [15:0] POSTWORD_IN,
  input wire [15:0] INSTRUCTION_COUNTER_IN,
  input wire DOUBLE_OP_IN,
  input wire [15:0] MEM_DATA_IN,
  input wire MEM_DATA_VALID_IN,
  output reg [47:0] RD_A_DATA_OUT,
  output reg [15:0] RD_B_DATA_OUT,
  output wire [15:0] STACK_PTR_OUT,
  output reg [15:0] OPERAND_OUT,
  output reg OPERAND_VALID_OUT,
  output reg [15:0] ADDR_OUT,
  output reg ADDR_VALID_OUT,
  output reg PTR_REQ_OUT,
  output reg [3:0] FIRST_REG_OUT,
  output wire BUSY_OUT
);

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT_PTR = 2'b10;

  // ==========================================================================
  // Register storage
  // ==========================================================================
  reg [WORD_W-1:0] gpr_q [0:NUM_REGS-1];
  reg [1:0] state_q;
  reg [1:0] state_d;
  wire [3:0] rd_a_next1;
  wire [3:0] rd_a_next2;
  wire start_ok;

  // A lone push or pop owns register 15 in its cycle, so a write aimed there is dropped; push with pop lets it through.
  wire stack_step = PUSH_MULTIPLE_OP_IN ^ POP_MULTIPLE_OP_IN;
  wire [15:0] stack_ptr_d = PUSH_MULTIPLE_OP_IN ? (gpr_q[`GPROD_REG_STACK_PTR] - `GPROD_SHORT_ONE)
                                                : (gpr_q[`GPROD_REG_STACK_PTR] + `GPROD_SHORT_ONE);

  // One writer per register, each flip-flop updates at the clock edge.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi = gi + 1) begin : g_gpr
      always @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          gpr_q[gi] <= `GPROD_REG_RESET;
        end else if ((gi == `GPROD_REG_STACK_PTR) && stack_step) begin
          gpr_q[gi] <= stack_ptr_d;
        end else if (WR_EN_IN && (WR_ADDR_IN == gi)) begin
          gpr_q[gi] <= WR_DATA_IN;
        end
      end
    end
  endgenerate

  // The stack pointer is register 15 itself.
  assign STACK_PTR_OUT = gpr_q[`GPROD_REG_STACK_PTR];

  // ==========================================================================
  // Read ports
  // ==========================================================================
  // Four-bit sums drop their carry, which gives the wrap from 15 to 0.
  assign rd_a_next1 = RD_A_ADDR_IN + 4'h1;
  assign rd_a_next2 = RD_A_ADDR_IN + 4'h2;

  // Port A returns three words, most significant at the named register.
  // A read in the same cycle as a write returns the value before the write.
  always @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RD_A_DATA_OUT <= {3{`GPROD_REG_RESET}};
      RD_B_DATA_OUT <= `GPROD_REG_RESET;
    end else begin
      RD_A_DATA_OUT <= {gpr_q[RD_A_ADDR_IN], gpr_q[rd_a_next1], gpr_q[rd_a_next2]};
      RD_B_DATA_OUT <= gpr_q[RD_B_ADDR_IN];
    end
  end

  // ==========================================================================
  // Operand derivation arithmetic
  // ==========================================================================
  // Index contributes only when its field is nonzero.
  wire index_used = (INDEX_FIELD_IN != `GPROD_REG_NO_INDEX);
  wire [15:0] index_val = index_used ? gpr_q[INDEX_FIELD_IN] : `GPROD_REG_RESET;
  wire [3:0] base_reg = `GPROD_REG_BASE_FIRST + {2'b00, BASE_SEL_IN};
  wire [15:0] base_val = gpr_q[base_reg];
  // All sums are 16 bits wide; the carry out of bit 15 is lost.
  wire [15:0] post_indexed = POSTWORD_IN + index_val;
  wire [15:0] disp_sext = {{8{DISP_IN[7]}}, DISP_IN};
  wire [15:0] counter_rel = INSTRUCTION_COUNTER_IN + disp_sext;
  wire [15:0] base_disp = base_val + {`GPROD_ZERO_HIGH_BYTE, DISP_IN};
  wire [15:0] base_index = base_val + index_val;
  wire [15:0] short_pos = {`GPROD_ZERO_HIGH_NIBBLES, SHORT_FIELD_IN} + `GPROD_SHORT_ONE;
  wire [15:0] short_neg = {`GPROD_SHORT_NEG_HIGH, ~SHORT_FIELD_IN};
  wire is_base_mode = (MODE_IN == `GPROD_MODE_BASE) || (MODE_IN == `GPROD_MODE_BASE_INDEXED);

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  assign BUSY_OUT = (state_q != ST_IDLE);
  assign start_ok = START_IN && (state_q == ST_IDLE);

  // Next state: only the indirect mode leaves idle, to wait for the pointer.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_ok && (MODE_IN == `GPROD_MODE_MEM_INDIRECT)) begin
          state_d = ST_WAIT_PTR;
        end
      end
      ST_WAIT_PTR: begin
        if (MEM_DATA_VALID_IN) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Result registers
  // ==========================================================================
  // Valid and request strobes last one cycle; data holds until the next result.
  always @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      OPERAND_OUT <= `GPROD_REG_RESET;
      OPERAND_VALID_OUT <= 1'b0;
      ADDR_OUT <= `GPROD_REG_RESET;
      ADDR_VALID_OUT <= 1'b0;
      PTR_REQ_OUT <= 1'b0;
      FIRST_REG_OUT <= `GPROD_REG_NO_INDEX;
    end else begin
      OPERAND_VALID_OUT <= 1'b0;
      ADDR_VALID_OUT <= 1'b0;
      PTR_REQ_OUT <= 1'b0;
      if (state_q == ST_WAIT_PTR) begin
        if (MEM_DATA_VALID_IN) begin
          ADDR_OUT <= MEM_DATA_IN;
          ADDR_VALID_OUT <= 1'b1;
        end
      end else if (start_ok) begin
        if (is_base_mode) begin
          FIRST_REG_OUT <= DOUBLE_OP_IN ? `GPROD_REG_DOUBLE_BASE_FIRST
                                        : `GPROD_REG_SINGLE_BASE_FIRST;
        end else begin
          FIRST_REG_OUT <= REG_FIELD_IN;
        end
        case (MODE_IN)
          `GPROD_MODE_REG_DIRECT: begin
            OPERAND_OUT <= gpr_q[REG_FIELD_IN];
            OPERAND_VALID_OUT <= 1'b1;
          end
          `GPROD_MODE_MEM_DIRECT: begin
            ADDR_OUT <= post_indexed;
            ADDR_VALID_OUT <= 1'b1;
          end
          `GPROD_MODE_MEM_INDIRECT: begin
            ADDR_OUT <= post_indexed;
            PTR_REQ_OUT <= 1'b1;
          end
          `GPROD_MODE_IMMEDIATE_LONG: begin
            OPERAND_OUT <= post_indexed;
            OPERAND_VALID_OUT <= 1'b1;
          end
          `GPROD_MODE_SHORT_POS: begin
            OPERAND_OUT <= short_pos;
            OPERAND_VALID_OUT <= 1'b1;
          end
          `GPROD_MODE_SHORT_NEG: begin
            OPERAND_OUT <= short_neg;
            OPERAND_VALID_OUT <= 1'b1;
          end
          `GPROD_MODE_COUNTER_REL: begin
            ADDR_OUT <= counter_rel;
            ADDR_VALID_OUT <= 1'b1;
          end
          `GPROD_MODE_BASE: begin
            ADDR_OUT <= base_disp;
            ADDR_VALID_OUT <= 1'b1;
          end
          `GPROD_MODE_BASE_INDEXED: begin
            ADDR_OUT <= base_index;
            ADDR_VALID_OUT <= 1'b1;
          end
          default: begin
            OPERAND_VALID_OUT <= 1'b0; // Unused mode codes raise no valid strobe.
          end
        endcase
      end
    end
  end

endmodule

//--- tb/gprod_properties.sv
/* Checker for gprod_top: derived operands, addresses and stack pointer timing.
   Assumes it is bound to gprod_top and sees only its ports. */
`timescale 1ns/1ns
module gprod_checker (
  input wire CLK_SYS_IN, RST_N_IN, START_IN, BUSY_OUT, DOUBLE_OP_IN,
  input wire OPERAND_VALID_OUT, ADDR_VALID_OUT, PTR_REQ_OUT, MEM_DATA_VALID_IN,
  input wire PUSH_MULTIPLE_OP_IN, POP_MULTIPLE_OP_IN,
  input wire [3:0] MODE_IN, SHORT_FIELD_IN, FIRST_REG_OUT,
  input wire [7:0] DISP_IN,
  input wire [15:0] INSTRUCTION_COUNTER_IN, MEM_DATA_IN, OPERAND_OUT, ADDR_OUT, STACK_PTR_OUT
);
  // ==========
  // Clocking, accepted starts and the sign-extended displacement.
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  wire go = START_IN && !BUSY_OUT;
  wire [15:0] sdisp = {{8{DISP_IN[7]}}, DISP_IN};
  // ==========
  // Each result is tied to the request that caused it.
  a_short_pos_val: assert property (
    go && MODE_IN == 4'h4 |=> OPERAND_VALID_OUT && OPERAND_OUT == $past(SHORT_FIELD_IN) + 16'h0001)
    else $error("short positive operand wrong");
  a_short_neg_val: assert property (
    go && MODE_IN == 4'h5 |=> OPERAND_OUT == ~{12'h000, $past(SHORT_FIELD_IN)})
    else $error("short negative operand wrong");
  a_counter_rel_addr: assert property (
    go && MODE_IN == 4'h6 |=> ADDR_VALID_OUT && ADDR_OUT == $past(INSTRUCTION_COUNTER_IN) + $past(sdisp))
    else $error("counter relative address wrong");
  a_base_first_reg: assert property (
    go && MODE_IN[3:1] != 3'h0 && MODE_IN[2:0] != 3'h0 && MODE_IN > 4'h6 && MODE_IN < 4'h9
    |=> FIRST_REG_OUT == ($past(DOUBLE_OP_IN) ? 4'h0 : 4'h2)) else $error("implied register wrong");
  a_ptr_req_busy: assert property (
    go && MODE_IN == 4'h2 |=> PTR_REQ_OUT && BUSY_OUT && !ADDR_VALID_OUT)
    else $error("pointer request missing");
  a_ptr_to_addr: assert property (
    BUSY_OUT && MEM_DATA_VALID_IN |=> ADDR_VALID_OUT && !BUSY_OUT && ADDR_OUT == $past(MEM_DATA_IN))
    else $error("pointer not used as address");
  a_stack_push_dec: assert property (
    PUSH_MULTIPLE_OP_IN && !POP_MULTIPLE_OP_IN |=> STACK_PTR_OUT == $past(STACK_PTR_OUT) - 16'h0001)
    else $error("push did not decrement");
  a_bad_mode_quiet: assert property (
    go && MODE_IN > 4'h8 |=> !OPERAND_VALID_OUT && !ADDR_VALID_OUT)
    else $error("unused mode gave a result");
endmodule
bind gprod_top gprod_checker u_chk (.*);

//--- tb/gprod_mem_model.sv
/* Memory unit stand-in that answers pointer reads with the inverted address.
   Assumes addr_in holds the pointer address from the request until the answer. */
`timescale 1ns/1ns
module gprod_mem_model (
  input wire clk_in,
  input wire rst_n_in,
  input wire req_in,
  input wire [15:0] addr_in,
  input wire [2:0] delay_in,
  output reg valid_out,
  output reg [15:0] data_out
);
  reg [3:0] cnt_q;
  // Counts delay_in+1 idle cycles after a request, then pulses valid; data toggles when stale.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 4'h0;
      valid_out <= 1'b0;
      data_out <= 16'h0000;
    end else begin
      valid_out <= (cnt_q == 4'h1);
      data_out <= (cnt_q == 4'h1) ? ~addr_in : ~data_out;
      cnt_q <= req_in ? {1'b0, delay_in} + 4'h1 : (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
    end
  end
endmodule

//--- tb/gprod_top_tb.sv
/* Self-checking bench for gprod_top.
   Assumes gprod_mem_model answers pointer reads and the checker is bound. */
`timescale 1ns/1ns
module gprod_top_tb;
  reg CLK_SYS_IN = 1'b0, RST_N_IN = 1'b0, WR_EN_IN = 1'b0, START_IN = 1'b0, DOUBLE_OP_IN = 1'b0;
  reg PUSH_MULTIPLE_OP_IN = 1'b0, POP_MULTIPLE_OP_IN = 1'b0;
  reg [3:0] WR_ADDR_IN = 4'h0, RD_A_ADDR_IN = 4'h0, RD_B_ADDR_IN = 4'h0, MODE_IN = 4'h0;
  reg [3:0] REG_FIELD_IN = 4'h7, INDEX_FIELD_IN = 4'h0, SHORT_FIELD_IN = 4'h0, k;
  reg [1:0] BASE_SEL_IN = 2'h2;
  reg [7:0] DISP_IN = 8'h00;
  reg [15:0] WR_DATA_IN = 16'h0000, POSTWORD_IN = 16'hfff0, INSTRUCTION_COUNTER_IN = 16'h0040, x;
  reg [15:0] rq [0:15];
  reg [2:0] dly = 3'h0;
  wire [47:0] RD_A_DATA_OUT;
  wire [15:0] RD_B_DATA_OUT, STACK_PTR_OUT, OPERAND_OUT, ADDR_OUT, MEM_DATA_IN;
  wire OPERAND_VALID_OUT, ADDR_VALID_OUT, PTR_REQ_OUT, BUSY_OUT, MEM_DATA_VALID_IN;
  wire [3:0] FIRST_REG_OUT;
  integer fails = 0, num_checks = 0, i;
  gprod_top u_dut (.*);
  gprod_mem_model u_mem (.clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN), .req_in(PTR_REQ_OUT),
    .addr_in(ADDR_OUT), .delay_in(dly), .valid_out(MEM_DATA_VALID_IN), .data_out(MEM_DATA_IN));
  // Moves to just after the next rising edge.
  task step;
    begin
      @(posedge CLK_SYS_IN);
      #2;
    end
  endtask
  // Compares a seen value with the expected one.
  task chk(input [47:0] seen, input [47:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task results;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  // Starts one derivation and waits, bounded, for its result pulse.
  task run(input [3:0] m);
    integer n;
    begin
      MODE_IN = m;
      START_IN = 1'b1;
      step;
      START_IN = 1'b0;
      for (n = 0; n < 12 && OPERAND_VALID_OUT !== 1'b1 && ADDR_VALID_OUT !== 1'b1; n = n + 1)
        step;
      if (n == 12) begin
        fails = fails + 1;
        results;
      end
    end
  endtask
  // Writes all registers back to back, then reads a group across the wrap and one ending at register 15.
  task t_regs;
    begin
      WR_EN_IN = 1'b1;
      for (i = 0; i < 16; i = i + 1) begin
        k = i;
        rq[k] = 16'hf00f + {k, k, k, k};
        WR_ADDR_IN = k;
        WR_DATA_IN = rq[k];
        step;
      end
      WR_ADDR_IN = 4'h5;
      WR_DATA_IN = 16'h1234;
      RD_A_ADDR_IN = 4'hf;
      RD_B_ADDR_IN = 4'h5;
      step;
      chk(RD_B_DATA_OUT, rq[5]);
      chk(RD_A_DATA_OUT, {rq[15], rq[0], rq[1]});
      WR_EN_IN = 1'b0;
      RD_A_ADDR_IN = 4'hd;
      step;
      chk(RD_A_DATA_OUT, {rq[13], rq[14], rq[15]});
      chk(RD_B_DATA_OUT, 16'h1234);
    end
  endtask
  // Runs the indexable modes without and with an index register.
  task t_index;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        INDEX_FIELD_IN = i ? 4'h3 : 4'h0;
        x = i ? rq[3] : 16'h0000;
        run(4'h0);
        chk(OPERAND_OUT, rq[7]);
        run(4'h1);
        chk(ADDR_OUT, 16'(POSTWORD_IN + x));
        run(4'h3);
        chk(OPERAND_OUT, 16'(POSTWORD_IN + x));
        run(4'h8);
        chk(ADDR_OUT, 16'(rq[14] + x));
        run(4'h2);
        chk(ADDR_OUT, 16'(~(POSTWORD_IN + x)));
        dly = 3'h5;
      end
    end
  endtask
  // Covers short immediates, counter relative and the base displacement mode at field limits.
  task t_fields;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        k = i ? 4'hf : 4'h0;
        SHORT_FIELD_IN = k;
        run(4'h4);
        chk(OPERAND_OUT, k + 5'h01);
        run(4'h5);
        chk(OPERAND_OUT, 16'(~{12'h000, k}));
        DISP_IN = i ? 8'h7f : 8'h80;
        run(4'h6);
        chk(ADDR_OUT, i ? 16'h00bf : 16'hffc0);
        DOUBLE_OP_IN = i[0];
        BASE_SEL_IN = 2'h3;
        DISP_IN = 8'hff;
        run(4'h7);
        chk(ADDR_OUT, 16'(rq[15] + 16'h00ff));
        chk(FIRST_REG_OUT, i ? 4'h0 : 4'h2);
      end
    end
  endtask
  // Unused mode, then push, cancelling push and pop, and pop beating a write.
  task t_stack;
    begin
      MODE_IN = 4'h9;
      START_IN = 1'b1;
      step;
      START_IN = 1'b0;
      chk({OPERAND_VALID_OUT, ADDR_VALID_OUT}, 2'b00);
      PUSH_MULTIPLE_OP_IN = 1'b1;
      step;
      chk(STACK_PTR_OUT, 16'(rq[15] - 16'h0001));
      POP_MULTIPLE_OP_IN = 1'b1;
      step;
      chk(STACK_PTR_OUT, 16'(rq[15] - 16'h0001));
      PUSH_MULTIPLE_OP_IN = 1'b0;
      WR_EN_IN = 1'b1;
      WR_ADDR_IN = 4'hf;
      step;
      WR_EN_IN = 1'b0;
      POP_MULTIPLE_OP_IN = 1'b0;
      chk(STACK_PTR_OUT, rq[15]);
    end
  endtask
  // Free-running system clock.
  initial begin
    forever #10 CLK_SYS_IN = ~CLK_SYS_IN;
  end
  // Reset, then every scenario in turn.
  initial begin
    repeat (8) @(posedge CLK_SYS_IN);
    #2;
    RST_N_IN = 1'b1;
    t_regs;
    $display("test registers done");
    t_index;
    $display("test indexed modes done");
    t_fields;
    $display("test field modes done");
    t_stack;
    $display("test stack done");
    results;
  end
endmodule
